// ===== rtl/pbma_arbiter.sv
// system controller end: arbiter, config mechanism one, idsel, bus monitor
// Function
// - one bus clock samples every step
// - address and data share 32 lines
// - one address cycle, then data cycles
// - bursts send first address, then auto-increment
// - host configures devices by mechanism one
// - slot idsel from AD16, AD17, AD18
// - master not owning raises its request
// - arbiter grants the requesting master's pair
// - granted master asserts frame, drives address
// - owner may start without a request
// - pairs 0,1,2 serve slots 1,2,3
// - round-robin choice among pending requests
// - park grant on owner, bridge excluded
`timescale 1ns/1ps
`default_nettype none
`include "pbma_map.svh"
module pbma_arbiter #(
  parameter logic [2:0] SLOTS_FITTED = 3'b111,
  parameter logic [3:0] PARK_EXCL = 4'b1000
) (
  input wire logic CLK_SYS, // parallel bus clock
  input wire logic RESET_N, // asynchronous reset, active low
  pbma_bus_if.arbiter BUS, // shared bus
  input wire logic CFG_REQ, // one-cycle config request
  input wire logic [31:0] CFG_ADDR, // mechanism one address word
  input wire logic CFG_WR, // 1 write, 0 read
  input wire logic [31:0] CFG_WDATA, // config write data
  output logic CFG_BUSY, // config access in progress
  output logic CFG_ACK, // one-cycle completion pulse
  output logic CFG_HIT, // access reached a slot
  output logic [31:0] CFG_RDATA, // config read data
  output logic GNT_VALID, // a slot or host grant is asserted
  output logic [1:0] BUS_OWNER, // current or last owner index
  output logic MON_VALID, // one-cycle data phase pulse
  output logic [31:0] MON_ADDR, // address of that data phase
  output logic [31:0] MON_DATA, // data of that data phase
  output logic [3:0] MON_CMD // command of the transaction
);
  pbma_pkg::pbma_arb_e arb_state;
  pbma_pkg::pbma_cfg_e cfg_state;
  logic [1:0] owner;
  logic [3:0] req_all;
  logic [3:0] gnt_all;
  logic [1:0] pick;
  logic pick_valid;
  logic others;
  logic bus_idle;
  logic host_req;
  logic [31:0] ca;
  logic [31:0] wdata;
  logic wr;
  logic [2:0] dec_slot;
  logic dec_hit;
  logic in_tr;
  logic [31:0] burst_addr;

  // round-robin search starting after the last owner
  function automatic logic [2:0] rr_pick(input logic [3:0] req,
                                         input logic [1:0] last);
    logic [1:0] k;
    rr_pick = 3'h0;
    for (int i = 1; i <= `PBMA_AGENTS; i++) begin
      k = last + i[1:0];
      if (req[k] && !rr_pick[2]) rr_pick = {1'b1, k};
    end
  endfunction : rr_pick

  assign bus_idle = BUS.frame_n && BUS.irdy_n;
  assign host_req = (cfg_state == pbma_pkg::CFG_WAIT);
  // unfitted slots cannot request
  assign req_all = {host_req, ~BUS.req_n & SLOTS_FITTED};
  assign {pick_valid, pick} = rr_pick(req_all, owner);
  assign others = |(req_all & ~(4'h1 << owner));

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      arb_state <= pbma_pkg::ARB_IDLE;
      owner <= 2'h0;
    end else begin
      case (arb_state)
        pbma_pkg::ARB_IDLE: begin
          if (bus_idle && pick_valid) begin
            owner <= pick;
            arb_state <= pbma_pkg::ARB_GRANT;
          end
        end
        pbma_pkg::ARB_GRANT: begin
          if (bus_idle && others) begin
            arb_state <= pbma_pkg::ARB_GAP;
          end else if (bus_idle && !req_all[owner] && PARK_EXCL[owner]) begin
            arb_state <= pbma_pkg::ARB_IDLE;
          end
        end
        pbma_pkg::ARB_GAP: begin
          if (bus_idle && pick_valid) begin
            owner <= pick;
            arb_state <= pbma_pkg::ARB_GRANT;
          end else if (!pick_valid) begin
            arb_state <= pbma_pkg::ARB_IDLE;
          end
        end
        default: arb_state <= pbma_pkg::ARB_IDLE;
      endcase
    end
  end

  // one-hot grant, never two at once; kept while parked
  assign gnt_all = (arb_state == pbma_pkg::ARB_GRANT) ?
                   (4'h1 << owner) : 4'h0;
  assign BUS.gnt_n = ~gnt_all[2:0];
  assign GNT_VALID = |gnt_all;
  assign BUS_OWNER = owner;

  // idsel of slots 1..3 hard-wired to address lines 16..18
  assign BUS.idsel = BUS.ad[`PBMA_IDSEL_LSB+2:`PBMA_IDSEL_LSB];

  // mechanism one decode: enable, bus 7, a fitted slot
  assign dec_slot = pbma_pkg::pbma_slot_of_dev(
                      ca[`PBMA_CA_DEV_MSB:`PBMA_CA_DEV_LSB]);
  assign dec_hit = ca[`PBMA_CA_EN_BIT] &&
                   (ca[`PBMA_CA_BUS_MSB:`PBMA_CA_BUS_LSB] == `PBMA_CFG_BUS) &&
                   !dec_slot[2] && SLOTS_FITTED[dec_slot[1:0]];

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_state <= pbma_pkg::CFG_IDLE;
      ca <= 32'h00000000;
      wdata <= 32'h00000000;
      wr <= 1'b0;
      CFG_ACK <= 1'b0;
      CFG_HIT <= 1'b0;
      CFG_RDATA <= 32'h00000000;
    end else begin
      CFG_ACK <= 1'b0;
      case (cfg_state)
        pbma_pkg::CFG_IDLE: begin
          if (CFG_REQ) begin
            ca <= CFG_ADDR;
            wdata <= CFG_WDATA;
            wr <= CFG_WR;
            cfg_state <= pbma_pkg::CFG_DONE;
          end
        end
        pbma_pkg::CFG_DONE: begin
          if (dec_hit) begin
            cfg_state <= pbma_pkg::CFG_WAIT;
          end else begin
            // no slot answers: master abort reads all ones
            CFG_ACK <= 1'b1;
            CFG_HIT <= 1'b0;
            CFG_RDATA <= `PBMA_ABORT_DATA;
            cfg_state <= pbma_pkg::CFG_IDLE;
          end
        end
        pbma_pkg::CFG_WAIT: begin
          if (gnt_all[`PBMA_HOST_AGENT] && bus_idle) begin
            cfg_state <= pbma_pkg::CFG_ADDR;
          end
        end
        pbma_pkg::CFG_ADDR: cfg_state <= pbma_pkg::CFG_DATA;
        pbma_pkg::CFG_DATA: begin
          CFG_ACK <= 1'b1;
          CFG_HIT <= 1'b1;
          CFG_RDATA <= wr ? wdata : BUS.ad;
          cfg_state <= pbma_pkg::CFG_IDLE;
        end
        default: cfg_state <= pbma_pkg::CFG_IDLE;
      endcase
    end
  end

  assign CFG_BUSY = (cfg_state != pbma_pkg::CFG_IDLE);

  // host bus drive, registered so it lines up with the cycle phases
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      BUS.h_ad <= 32'h00000000;
      BUS.h_ad_oe <= 1'b0;
      BUS.h_cbe_n <= 4'hF;
      BUS.h_frame_n <= 1'b1;
      BUS.h_irdy_n <= 1'b1;
      BUS.h_ctl_oe <= 1'b0;
    end else begin
      BUS.h_ad_oe <= 1'b0;
      BUS.h_ctl_oe <= 1'b0;
      BUS.h_frame_n <= 1'b1;
      BUS.h_irdy_n <= 1'b1;
      BUS.h_cbe_n <= 4'hF;
      if (cfg_state == pbma_pkg::CFG_WAIT && gnt_all[`PBMA_HOST_AGENT] &&
          bus_idle) begin
        // type 0 address: one-hot idsel line, function and register
        BUS.h_ad <= (32'h00000001 << (`PBMA_IDSEL_LSB + dec_slot[1:0])) |
                    {21'h000000, ca[`PBMA_CA_FREG_MSB:`PBMA_CA_FREG_LSB],
                     2'h0};
        BUS.h_ad_oe <= 1'b1;
        BUS.h_cbe_n <= wr ? `PBMA_CMD_CFG_WR : `PBMA_CMD_CFG_RD;
        BUS.h_frame_n <= 1'b0;
        BUS.h_ctl_oe <= 1'b1;
      end else if (cfg_state == pbma_pkg::CFG_ADDR) begin
        // single data phase: frame released, irdy asserted
        BUS.h_ad <= wdata;
        BUS.h_ad_oe <= wr;
        BUS.h_cbe_n <= `PBMA_BE_ALL_N;
        BUS.h_irdy_n <= 1'b0;
        BUS.h_ctl_oe <= 1'b1;
      end
    end
  end

  // monitor: tracks burst address across data phases
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      in_tr <= 1'b0;
      burst_addr <= 32'h00000000;
      MON_VALID <= 1'b0;
      MON_ADDR <= 32'h00000000;
      MON_DATA <= 32'h00000000;
      MON_CMD <= 4'h0;
    end else begin
      MON_VALID <= 1'b0;
      if (!in_tr && !BUS.frame_n) begin
        in_tr <= 1'b1;
        burst_addr <= BUS.ad;
        MON_CMD <= BUS.cbe_n;
      end else if (in_tr && !BUS.irdy_n) begin
        MON_VALID <= 1'b1;
        MON_ADDR <= burst_addr;
        MON_DATA <= BUS.ad;
        burst_addr <= burst_addr + `PBMA_ADDR_STEP;
        if (BUS.frame_n) in_tr <= 1'b0;
      end
    end
  end
endmodule : pbma_arbiter
`default_nettype wire

// ===== rtl/pbma_map.svh
// constants of the parallel bus master arbiter: commands, wiring, layouts
`ifndef PBMA_MAP_SVH
`define PBMA_MAP_SVH

`define PBMA_BUS_MHZ 33
`define PBMA_AD_W 32
`define PBMA_SLOTS 3
`define PBMA_AGENTS 4
`define PBMA_HOST_AGENT 2'h3
`define PBMA_CMD_CFG_RD 4'hA
`define PBMA_CMD_CFG_WR 4'hB
`define PBMA_CFG_BUS 8'h07
`define PBMA_DEV_SLOT1 5'h04
`define PBMA_DEV_SLOT2 5'h0B
`define PBMA_DEV_SLOT3 5'h0A
`define PBMA_IDSEL_LSB 16
`define PBMA_CA_EN_BIT 31
`define PBMA_CA_BUS_MSB 23
`define PBMA_CA_BUS_LSB 16
`define PBMA_CA_DEV_MSB 15
`define PBMA_CA_DEV_LSB 11
`define PBMA_CA_FREG_MSB 10
`define PBMA_CA_FREG_LSB 2
`define PBMA_ABORT_DATA 32'hFFFFFFFF
`define PBMA_ADDR_STEP 32'h00000004
`define PBMA_BE_ALL_N 4'h0

`endif

// ===== rtl/pbma_pkg.sv
// types and shared decoding of the parallel bus master arbiter
`include "pbma_map.svh"
package pbma_pkg;
  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_GRANT = 2'b01,
    ARB_GAP = 2'b10
  } pbma_arb_e;

  typedef enum logic [2:0] {
    CFG_IDLE = 3'b000,
    CFG_WAIT = 3'b001,
    CFG_ADDR = 3'b010,
    CFG_DATA = 3'b011,
    CFG_DONE = 3'b100
  } pbma_cfg_e;

  typedef enum logic [1:0] {
    MST_IDLE = 2'b00,
    MST_WAIT = 2'b01,
    MST_ADDR = 2'b10,
    MST_DATA = 2'b11
  } pbma_mst_e;

  // device number to slot index; bit 2 set when no slot carries it
  function automatic logic [2:0] pbma_slot_of_dev(input logic [4:0] dev);
    case (dev)
      `PBMA_DEV_SLOT1: pbma_slot_of_dev = 3'h0;
      `PBMA_DEV_SLOT2: pbma_slot_of_dev = 3'h1;
      `PBMA_DEV_SLOT3: pbma_slot_of_dev = 3'h2;
      default: pbma_slot_of_dev = 3'h4;
    endcase
  endfunction : pbma_slot_of_dev
endpackage : pbma_pkg

// ===== rtl/pbma_bus_if.sv
// shared parallel bus between the arbiter end and the slot masters
`timescale 1ns/1ps
`default_nettype none
`include "pbma_map.svh"
interface pbma_bus_if;
  logic [2:0] req_n;
  logic [2:0] gnt_n;
  logic [2:0] idsel;
  logic [2:0][31:0] m_ad;
  logic [2:0] m_ad_oe;
  logic [2:0][3:0] m_cbe_n;
  logic [2:0] m_frame_n;
  logic [2:0] m_irdy_n;
  logic [2:0] m_ctl_oe;
  logic [31:0] h_ad;
  logic h_ad_oe;
  logic [3:0] h_cbe_n;
  logic h_frame_n;
  logic h_irdy_n;
  logic h_ctl_oe;
  logic [31:0] ad;
  logic [3:0] cbe_n;
  logic frame_n;
  logic irdy_n;

  // wire resolution; undriven control lines float high as if pulled up
  always_comb begin
    ad = h_ad_oe ? h_ad : 32'h00000000;
    cbe_n = h_ctl_oe ? h_cbe_n : 4'hF;
    frame_n = h_ctl_oe ? h_frame_n : 1'b1;
    irdy_n = h_ctl_oe ? h_irdy_n : 1'b1;
    for (int s = 0; s < `PBMA_SLOTS; s++) begin
      if (m_ad_oe[s]) ad = ad | m_ad[s];
      if (m_ctl_oe[s]) begin
        cbe_n = cbe_n & m_cbe_n[s];
        frame_n = frame_n & m_frame_n[s];
        irdy_n = irdy_n & m_irdy_n[s];
      end
    end
  end

  modport arbiter (
    input req_n, ad, cbe_n, frame_n, irdy_n,
    output gnt_n, idsel, h_ad, h_ad_oe, h_cbe_n, h_frame_n, h_irdy_n,
    h_ctl_oe
  );
  modport master (
    input gnt_n, idsel, ad, cbe_n, frame_n, irdy_n,
    output req_n, m_ad, m_ad_oe, m_cbe_n, m_frame_n, m_irdy_n, m_ctl_oe
  );
endinterface : pbma_bus_if
`default_nettype wire

// ===== rtl/pbma_slot_master.sv
// add-in slot end: bus master issuing one burst per user request
`timescale 1ns/1ps
`default_nettype none
`include "pbma_map.svh"
module pbma_slot_master #(
  parameter int SLOT = 0,
  parameter int LEN_W = 8
) (
  input wire logic CLK_SYS, // parallel bus clock
  input wire logic RESET_N, // asynchronous reset, active low
  pbma_bus_if.master BUS, // shared bus
  input wire logic XFER_REQ, // one-cycle transfer request
  input wire logic [31:0] XFER_ADDR, // first burst address
  input wire logic [3:0] XFER_CMD, // bus command
  input wire logic [LEN_W-1:0] XFER_LEN, // data phases, zero taken as one
  input wire logic [31:0] XFER_WDATA, // word taken when BEAT_TAKE high
  output logic BEAT_TAKE, // XFER_WDATA sampled this edge
  output logic XFER_BUSY, // request pending or burst running
  output logic XFER_DONE, // one-cycle end-of-burst pulse
  output logic [31:0] XFER_RDATA, // last data phase word seen
  output logic SLOT_SELECTED // idsel of this slot is high
);
  pbma_pkg::pbma_mst_e state;
  logic [31:0] addr;
  logic [3:0] cmd;
  logic [LEN_W-1:0] left;
  logic [31:0] ad_q;
  logic bus_idle;
  logic granted;
  logic frame_q;
  logic irdy_q;

  assign bus_idle = BUS.frame_n && BUS.irdy_n;
  assign granted = !BUS.gnt_n[SLOT];
  assign SLOT_SELECTED = BUS.idsel[SLOT];
  assign XFER_BUSY = (state != pbma_pkg::MST_IDLE);
  // request only while waiting and not already owning
  assign BUS.req_n[SLOT] = !(state == pbma_pkg::MST_WAIT && !granted);
  assign BEAT_TAKE = (state == pbma_pkg::MST_ADDR) ||
                     (state == pbma_pkg::MST_DATA && left > 1);

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= pbma_pkg::MST_IDLE;
      addr <= 32'h00000000;
      cmd <= 4'h0;
      left <= '0;
      XFER_DONE <= 1'b0;
    end else begin
      XFER_DONE <= 1'b0;
      case (state)
        pbma_pkg::MST_IDLE: begin
          if (XFER_REQ) begin
            addr <= XFER_ADDR;
            cmd <= XFER_CMD;
            left <= (XFER_LEN == '0) ? LEN_W'(1) : XFER_LEN;
            state <= pbma_pkg::MST_WAIT;
          end
        end
        pbma_pkg::MST_WAIT: begin
          // parked owner starts straight away
          if (granted && bus_idle) state <= pbma_pkg::MST_ADDR;
        end
        pbma_pkg::MST_ADDR: state <= pbma_pkg::MST_DATA;
        pbma_pkg::MST_DATA: begin
          left <= left - LEN_W'(1);
          if (left == LEN_W'(1)) begin
            XFER_DONE <= 1'b1;
            state <= pbma_pkg::MST_IDLE;
          end
        end
        default: state <= pbma_pkg::MST_IDLE;
      endcase
    end
  end

  // registered drive of the shared lines
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ad_q <= 32'h00000000;
      frame_q <= 1'b0;
      irdy_q <= 1'b0;
      XFER_RDATA <= 32'h00000000;
    end else begin
      if (state == pbma_pkg::MST_WAIT && granted && bus_idle) begin
        ad_q <= addr;
        frame_q <= 1'b1;
      end else if (BEAT_TAKE) begin
        ad_q <= XFER_WDATA;
        irdy_q <= 1'b1;
        frame_q <= (state == pbma_pkg::MST_ADDR) ? (left > 1) : (left > 2);
      end else begin
        frame_q <= 1'b0;
        irdy_q <= 1'b0;
      end
      if (state == pbma_pkg::MST_DATA) XFER_RDATA <= BUS.ad;
    end
  end

  assign BUS.m_ad[SLOT] = ad_q;
  assign BUS.m_ad_oe[SLOT] = frame_q || irdy_q;
  assign BUS.m_cbe_n[SLOT] = (state == pbma_pkg::MST_ADDR) ?
                             cmd : `PBMA_BE_ALL_N;
  assign BUS.m_frame_n[SLOT] = !frame_q;
  assign BUS.m_irdy_n[SLOT] = !irdy_q;
  assign BUS.m_ctl_oe[SLOT] = frame_q || irdy_q;
endmodule : pbma_slot_master
`default_nettype wire

// ===== verif/pbma_bus_monitor.sv
// concurrent checks on the shared parallel bus
`timescale 1ns/1ps
`default_nettype none
`include "pbma_map.svh"
module pbma_bus_monitor (
  input wire logic CLK_SYS, // bus clock
  input wire logic RESET_N, // reset, active low
  input wire logic [2:0] req_n, // slot requests
  input wire logic [2:0] gnt_n, // slot grants
  input wire logic [2:0] idsel, // slot selects
  input wire logic [31:0] ad, // address and data
  input wire logic [3:0] cbe_n, // command and enables
  input wire logic frame_n, // frame
  input wire logic irdy_n // initiator ready
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  a_one_grant: assert property (
    $onehot0(~gnt_n)) else $error("two grants");
  a_gap_between: assert property (
    gnt_n != 3'h7 && $past(gnt_n) != 3'h7 |-> gnt_n == $past(gnt_n))
    else $error("grant moved without gap");
  a_idle_only: assert property (
    !(frame_n && irdy_n) |=> $stable(gnt_n)) else $error("grant moved busy");
  a_grant_cause: assert property (
    (~gnt_n & $past(gnt_n) & $past(req_n)) == 3'h0)
    else $error("grant without request");
  a_addr_first: assert property (
    $fell(frame_n) |-> irdy_n ##1 !irdy_n) else $error("no data after addr");
  a_last_data: assert property (
    $rose(frame_n) |-> !irdy_n ##1 irdy_n) else $error("bad last data");
  a_master_owns: assert property (
    $fell(frame_n) && !(cbe_n inside {`PBMA_CMD_CFG_RD, `PBMA_CMD_CFG_WR})
    |-> $past(gnt_n) != 3'h7) else $error("frame without grant");
  a_idsel_wire: assert property (
    $fell(frame_n) && cbe_n inside {`PBMA_CMD_CFG_RD, `PBMA_CMD_CFG_WR}
    |-> idsel == ad[18:16] && ad[31:19] == 13'h0000 && ad[1:0] == 2'h0)
    else $error("config address not type zero");
  a_cfg_onehot: assert property (
    $fell(frame_n) && cbe_n inside {`PBMA_CMD_CFG_RD, `PBMA_CMD_CFG_WR}
    |-> $onehot(idsel)) else $error("config selects no one slot");
  a_slot_served: assert property (
    !req_n[0] |-> ##[0:200] !gnt_n[0]) else $error("slot never granted");
endmodule : pbma_bus_monitor
`default_nettype wire

// ===== verif/parallel_bus_master_arbiter_bench.sv
// bench: arbiter end facing three slot masters
`timescale 1ns/1ps
`default_nettype none
`include "pbma_map.svh"
module parallel_bus_master_arbiter_bench;
  logic clk_sys, reset_n, cfg_req, cfg_wr;
  logic [31:0] cfg_addr, cfg_wdata, cfg_rdata, mon_addr, mon_data;
  logic cfg_busy, cfg_ack, cfg_hit, gnt_valid, mon_valid;
  logic [1:0] bus_owner;
  logic [3:0] mon_cmd;
  logic [2:0] xreq, take, xbusy, xdone, xsel, req_seen, sel_seen, gprev;
  logic [2:0] done_seen;
  logic [31:0] xrdata [3];
  logic [31:0] xaddr [3];
  logic [31:0] xwdata [3];
  logic [3:0] xcmd [3];
  logic [7:0] xlen [3];
  logic [7:0] wcnt [3];
  logic [67:0] mq [$];
  logic [2:0] glog [$];
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  pbma_bus_if pbma_bus_if_i ();
  pbma_arbiter pbma_arbiter_i (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .BUS(pbma_bus_if_i),
    .CFG_REQ(cfg_req), .CFG_ADDR(cfg_addr), .CFG_WR(cfg_wr),
    .CFG_WDATA(cfg_wdata), .CFG_BUSY(cfg_busy), .CFG_ACK(cfg_ack),
    .CFG_HIT(cfg_hit), .CFG_RDATA(cfg_rdata), .GNT_VALID(gnt_valid),
    .BUS_OWNER(bus_owner), .MON_VALID(mon_valid), .MON_ADDR(mon_addr),
    .MON_DATA(mon_data), .MON_CMD(mon_cmd));
  for (genvar g = 0; g < 3; g++) begin : g_slot
    assign xwdata[g] = {8'hD0 + 8'(g), 16'h0000, wcnt[g]};
    pbma_slot_master #(.SLOT(g), .LEN_W(8)) pbma_slot_master_i (
      .CLK_SYS(clk_sys), .RESET_N(reset_n), .BUS(pbma_bus_if_i),
      .XFER_REQ(xreq[g]), .XFER_ADDR(xaddr[g]), .XFER_CMD(xcmd[g]),
      .XFER_LEN(xlen[g]), .XFER_WDATA(xwdata[g]), .BEAT_TAKE(take[g]),
      .XFER_BUSY(xbusy[g]), .XFER_DONE(xdone[g]), .XFER_RDATA(xrdata[g]),
      .SLOT_SELECTED(xsel[g]));
  end
  pbma_bus_monitor pbma_bus_monitor_i (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .req_n(pbma_bus_if_i.req_n),
    .gnt_n(pbma_bus_if_i.gnt_n), .idsel(pbma_bus_if_i.idsel),
    .ad(pbma_bus_if_i.ad), .cbe_n(pbma_bus_if_i.cbe_n),
    .frame_n(pbma_bus_if_i.frame_n), .irdy_n(pbma_bus_if_i.irdy_n));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // record data phases, grant moves, requests and selects
  always @(posedge clk_sys) begin
    cycles++;
    if (mon_valid === 1'b1)
      mq.push_back({mon_cmd, mon_addr, mon_data});
    if (pbma_bus_if_i.gnt_n != gprev && pbma_bus_if_i.gnt_n != 3'h7)
      glog.push_back(pbma_bus_if_i.gnt_n);
    gprev <= pbma_bus_if_i.gnt_n;
    req_seen <= req_seen | ~pbma_bus_if_i.req_n;
    sel_seen <= sel_seen | xsel;
    done_seen <= done_seen | xdone;
    for (int s = 0; s < 3; s++)
      wcnt[s] <= reset_n ? wcnt[s] + 8'(take[s]) : 8'h00;
    if (cycles == 6000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [67:0] seen,
    input logic [67:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic cfg(input logic wr, input logic [31:0] a,
    input logic [31:0] d, output int lat);
    cfg_wr = wr;
    cfg_addr = a;
    cfg_wdata = d;
    cfg_req = 1'b1;
    @(negedge clk_sys);
    cfg_req = 1'b0;
    lat = 0;
    while (cfg_ack !== 1'b1 && lat < 100) begin
      @(negedge clk_sys);
      lat++;
    end
    repeat (2) @(negedge clk_sys);
    check("config busy", cfg_busy, 1'b0);
  endtask : cfg

  // slots in the mask start together, slot s at a + s * 100h
  task automatic start(input logic [2:0] which, input logic [31:0] a,
    input logic [7:0] n);
    int k;
    for (int s = 0; s < 3; s++) begin
      xaddr[s] = a + 32'(s << 8);
      xlen[s] = n;
      xcmd[s] = 4'h7;
    end
    done_seen = 3'h0;
    xreq = which;
    @(negedge clk_sys);
    xreq = 3'h0;
    k = 0;
    while (xbusy !== 3'h0 && k < 300) begin
      @(negedge clk_sys);
      k++;
    end
    check("masters idle", xbusy, 3'h0);
    repeat (3) @(negedge clk_sys);
    check("done pulses", done_seen, which);
  endtask : start

  task automatic check_burst(input int i, input int s, input logic [31:0] a,
    input int n, input logic [7:0] w0);
    for (int k = 0; k < n; k++) begin
      logic [67:0] e;
      e = {4'h7, a + 32'(s << 8) + 32'(4 * k), 8'hD0 + 8'(s), 16'h0000,
        w0 + 8'(k)};
      check("burst beat", mq[i + k], e);
    end
  endtask : check_burst

  task automatic t_cfg_miss();
    logic [31:0] bad [3];
    int lat;
    bad = '{32'h00072000, 32'h80062000, 32'h80072800};
    for (int i = 0; i < 3; i++) begin
      cfg(1'b0, bad[i], 32'h00000000, lat);
      check("miss delay", lat, 1);
      check("miss hit", cfg_hit, 1'b0);
      check("miss data", cfg_rdata, `PBMA_ABORT_DATA);
    end
  endtask : t_cfg_miss

  task automatic t_burst();
    logic [7:0] w0;
    mq.delete();
    req_seen = 3'h0;
    w0 = wcnt[1];
    start(3'h2, 32'h00001000, 8'h04);
    check("request", req_seen[1], 1'b1);
    check("beats", mq.size(), 4);
    check_burst(0, 1, 32'h00001000, 4, w0);
    check("last word", xrdata[1], {8'hD1, 16'h0000, w0 + 8'h03});
    check("owner", bus_owner, 2'h1);
    check("parked", pbma_bus_if_i.gnt_n, 3'h5);
  endtask : t_burst

  task automatic t_rr();
    logic [7:0] w0, w2;
    mq.delete();
    glog.delete();
    w0 = wcnt[0];
    w2 = wcnt[2];
    start(3'h5, 32'h00002000, 8'h02);
    check("grants", glog.size(), 2);
    check("first grant", glog[0], 3'h3);
    check("second grant", glog[1], 3'h6);
    check_burst(0, 2, 32'h00002000, 2, w2);
    check_burst(2, 0, 32'h00002000, 2, w0);
    repeat (20) @(negedge clk_sys);
    check("parked", pbma_bus_if_i.gnt_n, 3'h6);
  endtask : t_rr

  task automatic t_owner();
    logic [7:0] w0;
    mq.delete();
    req_seen = 3'h0;
    w0 = wcnt[0];
    start(3'h1, 32'h00003000, 8'h00);
    check("owner request", req_seen[0], 1'b0);
    check("beats", mq.size(), 1);
    check_burst(0, 0, 32'h00003000, 1, w0);
  endtask : t_owner

  task automatic t_cfg_hits();
    logic [4:0] dev [3];
    logic [31:0] a, d;
    logic [67:0] e;
    int lat;
    dev = '{`PBMA_DEV_SLOT1, `PBMA_DEV_SLOT2, `PBMA_DEV_SLOT3};
    for (int s = 0; s < 3; s++) begin
      mq.delete();
      sel_seen = 3'h0;
      d = (s == 1) ? 32'h5A000001 : 32'h00000000;
      a = {1'b1, 7'h00, `PBMA_CFG_BUS, dev[s], 3'h0, 6'(s + 1), 2'h0};
      cfg(s == 1, a, d, lat);
      repeat (3) @(negedge clk_sys);
      e = {(s == 1) ? `PBMA_CMD_CFG_WR : `PBMA_CMD_CFG_RD,
        (32'h1 << (16 + s)) | 32'((s + 1) << 2), d};
      check("hit", cfg_hit, 1'b1);
      check("config data", cfg_rdata, d);
      check("select", sel_seen, 3'h1 << s);
      check("cycles", mq.size(), 1);
      check("config cycle", mq[0], e);
      check("bridge unparked", gnt_valid, 1'b0);
    end
  endtask : t_cfg_hits

  initial begin
    reset_n = 1'b0;
    cfg_req = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 32'h00000000;
    cfg_wdata = 32'h00000000;
    xreq = 3'h0;
    gprev = 3'h7;
    xaddr = '{default: 32'h00000000};
    xcmd = '{default: 4'h0};
    xlen = '{default: 8'h00};
    wcnt = '{default: 8'h00};
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    t_cfg_miss();
    t_burst();
    t_rr();
    t_owner();
    t_cfg_hits();
    stop_test();
  end
endmodule : parallel_bus_master_arbiter_bench
`default_nettype wire
